// ### hw/sec_mon_pkg.sv
// package for the security event monitor: register map, field layouts, timing
package sec_mon_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_EVENT = 8'h00;
    localparam logic [7:0] OFS_REACT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;
    localparam logic [7:0] OFS_EXEC_ALLOW = 8'h18;
    localparam logic [7:0] OFS_PART_BASE = 8'h20;
    localparam logic [7:0] OFS_PART_SPAN = 8'h10;

    localparam int NUM_DET = 7;
    localparam int NUM_PART = 4;

    // detector bit positions
    localparam int DET_FREQ = 0;
    localparam int DET_VOLT = 1;
    localparam int DET_TEMP = 2;
    localparam int DET_LIGHT = 3;
    localparam int DET_INSUL = 4;
    localparam int DET_SHIELD = 5;
    localparam int DET_GLITCH = 6;

    // interrupt status bit positions
    localparam int IRQ_DET = 0;
    localparam int IRQ_INVALID = 1;
    localparam int IRQ_EXEC = 2;
    localparam int IRQ_PROT = 3;
    localparam int IRQ_PRIV = 4;
    localparam int NUM_IRQ = 5;

    // partition attribute bits
    localparam int ATTR_R = 0;
    localparam int ATTR_W = 1;
    localparam int ATTR_USER = 2;
    localparam int ATTR_EN = 3;

    // reset values
    localparam logic [NUM_DET-1:0] REACT_RESET = 7'h7F;
    localparam logic [NUM_IRQ-1:0] IRQ_EN_RESET = 5'h00;
    localparam logic [7:0] EXEC_ALLOW_RESET = 8'h00;
    localparam logic [15:0] PART_ADDR_RESET = 16'h0000;
    localparam logic [3:0] PART_ATTR_RESET = 4'h0;

    // filter timing: pulses shorter than this are dropped
    localparam int RST_FILT_NS = 20;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RST_FILT_CYC = (RST_FILT_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    // external clock high/low phase must last at least this many cycles
    localparam int EXT_CLK_MIN_CYC = 2;
    localparam int CHIP_RST_CYC = 16;

    // test password value is arbitrary
    localparam logic [31:0] TEST_PASSWORD = 32'h5A3C_96E1;

    typedef enum logic [1:0] {
        LC_LOCKED = 2'b00,
        LC_TEST = 2'b01,
        LC_NORMAL = 2'b10
    } life_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic priv;
        logic [15:0] addr;
    } cpu_acc_type;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic [3:0] attr;
    } part_type;

endpackage

// ### hw/security_event_monitor.sv
// security event monitor: detectors, pad filters, access checks, life cycle
//
// Behaviour
// - every detector event is latched into a software readable register
// - reset reaction selected: any detector event resets chip at once
// - flag reaction selected: light, insulation or shield event sets status bit, chip keeps running
// - seven detector inputs: frequency, voltage, temperature, light, ...
// - frequency, voltage, temperature or glitch fault forces reset
// - external reset and clock pads are filtered against glitches
// - shield removal or probing stops the chip: reset or fast interrupt
// - access to an invalid address raises a fast interrupt once partition 0 or 1 has attributes set
// - EEPROM fetch outside allowed regions raises a fast interrupt
// - security registers accessible only with required attributes
// - privileged or user cpu mode is the access attribute
// - all registers including protection settings take defaults at reset
// - software defines memory partitions with own protection attributes
// - prohibited accesses are trapped and never complete
// - test to normal transition is one way; test functions then locked
// - test state entered only after correct password from tester
// - functional tests like checksum allowed only in test state
// - detection and filtering cannot be disabled; only reaction chosen
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

module security_event_monitor
    import sec_mon_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hprot_priv,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // detectors and pads
    input wire logic [NUM_DET-1:0] det_raw,
    input wire logic ext_rst_n_pad,
    input wire logic ext_clk_pad,
    output logic ext_rst_n_filt,
    output logic ext_clk_filt,
    // cpu access monitor
    input wire cpu_acc_type cpu_acc,
    input wire logic [7:0] eeprom_region,
    input wire logic eeprom_fetch,
    output logic cpu_abort,
    // test port
    input wire logic test_pw_valid,
    input wire logic [31:0] test_pw,
    input wire logic test_cmd_valid,
    input wire logic test_checksum_ok,
    output logic test_cmd_ok,
    output logic test_pass,
    // reactions
    output logic chip_reset_req,
    output logic fast_interrupt_request,
    output logic [1:0] life_state
);

    // two-stage synchronisers for the detector inputs and the external reset and clock pads
    logic [NUM_DET-1:0] det_s1_q, det_s2_q, det_prev_q;
    logic rst_s1_q, rst_s2_q, clk_s1_q, clk_s2_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            det_s1_q <= '0;
            det_s2_q <= '0;
            det_prev_q <= '0;
            rst_s1_q <= 1'b1;
            rst_s2_q <= 1'b1;
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
        end else begin
            det_s1_q <= det_raw;
            det_s2_q <= det_s1_q;
            det_prev_q <= det_s2_q;
            rst_s1_q <= ext_rst_n_pad;
            rst_s2_q <= rst_s1_q;
            clk_s1_q <= ext_clk_pad;
            clk_s2_q <= clk_s1_q;
        end
    end

    wire [NUM_DET-1:0] det_rise = det_s2_q & ~det_prev_q;

    // reset filter: output follows pad only after it held steady long enough
    logic [7:0] rst_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_q <= '0;
            ext_rst_n_filt <= 1'b1;
        end else if (rst_s2_q == ext_rst_n_filt) begin
            rst_cnt_q <= '0;
        end else if (rst_cnt_q == 8'(RST_FILT_CYC - 1)) begin
            rst_cnt_q <= '0;
            ext_rst_n_filt <= rst_s2_q;
        end else begin
            rst_cnt_q <= rst_cnt_q + 8'h01;
        end
    end

    // clock filter: phases too short (too high a frequency) are swallowed
    logic [3:0] clk_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clk_cnt_q <= '0;
            ext_clk_filt <= 1'b0;
        end else if (clk_s2_q == ext_clk_filt) begin
            clk_cnt_q <= '0;
        end else if (clk_cnt_q == 4'(EXT_CLK_MIN_CYC - 1)) begin
            clk_cnt_q <= '0;
            ext_clk_filt <= clk_s2_q;
        end else begin
            clk_cnt_q <= clk_cnt_q + 4'h1;
        end
    end

    // ahb address phase capture
    logic wr_pend_q, rd_pend_q;
    logic [7:0] addr_q;
    logic priv_q;
    wire take = hsel && hready && htrans[1];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= '0;
            priv_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            addr_q <= haddr[7:0];
            priv_q <= hprot_priv;
        end
    end

    // only privileged accesses may touch the security registers
    wire wr_ok = wr_pend_q && priv_q;
    wire rd_ok = rd_pend_q && priv_q;
    wire priv_viol = (wr_pend_q || rd_pend_q) && !priv_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // reaction select and interrupt enable
    logic [NUM_DET-1:0] react_q;
    logic [NUM_IRQ-1:0] irq_en_q;
    logic [7:0] exec_allow_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            react_q <= REACT_RESET;
            irq_en_q <= IRQ_EN_RESET;
            exec_allow_q <= EXEC_ALLOW_RESET;
        end else if (wr_ok) begin
            if (hit(addr_q, OFS_REACT)) react_q <= hwdata[NUM_DET-1:0];
            if (hit(addr_q, OFS_IRQ_ENABLE)) irq_en_q <= hwdata[NUM_IRQ-1:0];
            if (hit(addr_q, OFS_EXEC_ALLOW)) exec_allow_q <= hwdata[7:0];
        end
    end

    // partitions: lo, hi, attr words per entry
    part_type part_q [NUM_PART];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PART; gi++) begin : g_part
            localparam logic [7:0] BASE = 8'(OFS_PART_BASE + gi * OFS_PART_SPAN);
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    part_q[gi] <= '{PART_ADDR_RESET, PART_ADDR_RESET,
                                    PART_ATTR_RESET};
                end else if (wr_ok) begin
                    if (hit(addr_q, BASE)) part_q[gi].lo <= hwdata[15:0];
                    if (hit(addr_q, BASE + 8'h04))
                        part_q[gi].hi <= hwdata[15:0];
                    if (hit(addr_q, BASE + 8'h08))
                        part_q[gi].attr <= hwdata[3:0];
                end
            end
        end
    endgenerate

    // memory protection check on every cpu access
    logic prot_hit, prot_ok;
    always_comb begin
        prot_hit = 1'b0;
        prot_ok = 1'b0;
        for (int i = 0; i < NUM_PART; i++) begin
            if (part_q[i].attr[ATTR_EN] && cpu_acc.addr >= part_q[i].lo &&
                cpu_acc.addr <= part_q[i].hi) begin
                prot_hit = 1'b1;
                if ((cpu_acc.priv || part_q[i].attr[ATTR_USER]) &&
                    (cpu_acc.write ? part_q[i].attr[ATTR_W]
                                   : part_q[i].attr[ATTR_R]))
                    prot_ok = 1'b1;
            end
        end
    end

    wire prot_viol = cpu_acc.valid && prot_hit && !prot_ok;
    // unmapped partition space counts as an invalid address once partition 0 or 1 has any attr bit set
    wire inv_addr = cpu_acc.valid && !prot_hit &&
        (|part_q[0].attr || |part_q[1].attr) ;
    wire exec_viol = cpu_acc.valid && cpu_acc.fetch && eeprom_fetch &&
        !exec_allow_q[eeprom_region[2:0]];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cpu_abort <= 1'b0;
        else cpu_abort <= prot_viol || inv_addr || exec_viol;
    end

    // detector event record: hardware set wins over software clear
    logic [NUM_DET-1:0] event_q;
    wire ev_clr = wr_ok && hit(addr_q, OFS_EVENT);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) event_q <= '0;
        else event_q <= (event_q & ~(ev_clr ? hwdata[NUM_DET-1:0] : '0))
            | det_rise;
    end

    // environmental faults always reset; others follow the reaction select
    localparam logic [NUM_DET-1:0] ENV_MASK = NUM_DET'((1 << DET_FREQ) |
        (1 << DET_VOLT) | (1 << DET_TEMP) | (1 << DET_GLITCH));
    wire [NUM_DET-1:0] rst_cause = det_rise & (react_q | ENV_MASK);
    wire [NUM_DET-1:0] flag_cause = det_rise & ~(react_q | ENV_MASK);

    // chip reset request stretched so reset logic sees it
    logic [4:0] crst_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crst_cnt_q <= '0;
            chip_reset_req <= 1'b0;
        end else if (|rst_cause) begin
            crst_cnt_q <= 5'(CHIP_RST_CYC - 1);
            chip_reset_req <= 1'b1;
        end else if (crst_cnt_q != 5'h00) begin
            crst_cnt_q <= crst_cnt_q - 5'h01;
        end else begin
            chip_reset_req <= 1'b0;
        end
    end

    // sticky interrupt status
    logic [NUM_IRQ-1:0] irq_st_q, irq_set;
    wire irq_clr = wr_ok && hit(addr_q, OFS_IRQ_CLEAR);
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_DET] = |flag_cause;
        irq_set[IRQ_INVALID] = inv_addr;
        irq_set[IRQ_EXEC] = exec_viol;
        irq_set[IRQ_PROT] = prot_viol;
        irq_set[IRQ_PRIV] = priv_viol;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) irq_st_q <= '0;
        else irq_st_q <= (irq_st_q & ~(irq_clr ? hwdata[NUM_IRQ-1:0] : '0))
            | irq_set;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) fast_interrupt_request <= 1'b0;
        else fast_interrupt_request <= |(irq_st_q & irq_en_q);
    end

    // life cycle: locked -> test (password) -> normal, never back
    life_type life_q;
    wire go_normal = wr_ok && hit(addr_q, OFS_MODE) && hwdata[0];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            life_q <= LC_LOCKED;
        end else begin
            case (life_q)
                LC_LOCKED: begin
                    if (test_pw_valid && test_pw == TEST_PASSWORD)
                        life_q <= LC_TEST;
                    else if (go_normal)
                        life_q <= LC_NORMAL;
                end
                LC_TEST: begin
                    if (go_normal) life_q <= LC_NORMAL;
                end
                LC_NORMAL: life_q <= LC_NORMAL;
                default: life_q <= LC_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            test_cmd_ok <= 1'b0;
            test_pass <= 1'b0;
            life_state <= LC_LOCKED;
        end else begin
            life_state <= life_q;
            test_cmd_ok <= test_cmd_valid && life_q == LC_TEST;
            test_pass <= test_cmd_valid && life_q == LC_TEST &&
                test_checksum_ok;
        end
    end

    // read data mux
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit(addr_q, OFS_EVENT)) rd_d[NUM_DET-1:0] = event_q;
        if (hit(addr_q, OFS_REACT)) rd_d[NUM_DET-1:0] = react_q;
        if (hit(addr_q, OFS_IRQ_STATUS)) rd_d[NUM_IRQ-1:0] = irq_st_q;
        if (hit(addr_q, OFS_IRQ_ENABLE)) rd_d[NUM_IRQ-1:0] = irq_en_q;
        if (hit(addr_q, OFS_MODE)) rd_d[1:0] = life_q;
        if (hit(addr_q, OFS_EXEC_ALLOW)) rd_d[7:0] = exec_allow_q;
        for (int i = 0; i < NUM_PART; i++) begin
            if (hit(addr_q, 8'(OFS_PART_BASE + i * OFS_PART_SPAN)))
                rd_d[15:0] = part_q[i].lo;
            if (hit(addr_q, 8'(OFS_PART_BASE + i * OFS_PART_SPAN + 4)))
                rd_d[15:0] = part_q[i].hi;
            if (hit(addr_q, 8'(OFS_PART_BASE + i * OFS_PART_SPAN + 8)))
                rd_d[3:0] = part_q[i].attr;
        end
    end

    // read data is registered, so reads take one wait state
    logic rd_wait_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_wait_q <= 1'b0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_pend_q && !rd_wait_q) begin
                rd_wait_q <= 1'b1;
                hreadyout <= 1'b1;
                hrdata <= rd_ok ? rd_d : 32'h0000_0000;
            end else begin
                rd_wait_q <= 1'b0;
                hreadyout <= !(take && !hwrite);
            end
        end
    end

endmodule

// ### bench/sem_checker.sv
// assertion checker bound to the security event monitor ports
`timescale 1ns/1ps

module sem_checker
    import sec_mon_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // detectors, pads, cpu
    input wire logic [NUM_DET-1:0] det_raw,
    input wire logic ext_clk_filt,
    input wire cpu_acc_type cpu_acc,
    input wire logic cpu_abort,
    // test port and reactions
    input wire logic test_pw_valid,
    input wire logic [31:0] test_pw,
    input wire logic test_cmd_valid,
    input wire logic test_checksum_ok,
    input wire logic test_cmd_ok,
    input wire logic test_pass,
    input wire logic chip_reset_req,
    input wire logic [1:0] life_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_write_nowait: assert property (
        hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write inserted a wait state");
    a_read_wait: assert property (
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_pass_needs_pw: assert property (
        life_state == LC_TEST && $past(life_state) == LC_LOCKED |->
        $past(test_pw_valid, 2) && $past(test_pw, 2) == TEST_PASSWORD)
        else $error("test entry without valid password");
    a_cmd_in_test: assert property (test_cmd_ok |->
        $past(test_cmd_valid) && life_state == LC_TEST)
        else $error("test command accepted outside test state");
    a_pass_in_test: assert property (test_pass |->
        $past(test_cmd_valid) && $past(test_checksum_ok) &&
        life_state == LC_TEST)
        else $error("checksum pass outside test state");
    a_normal_stays: assert property (
        life_state == LC_NORMAL |=> life_state == LC_NORMAL)
        else $error("left normal state");
    a_clk_phase: assert property (
        $changed(ext_clk_filt) |=> $stable(ext_clk_filt))
        else $error("filtered clock phase too short");
    a_reset_hold: assert property (
        $rose(chip_reset_req) |-> chip_reset_req [*8])
        else $error("chip reset request too short");
    a_fault_reset: assert property (
        $rose(det_raw[DET_FREQ]) |-> ##[1:6] chip_reset_req)
        else $error("frequency fault gave no reset");
    a_abort_cause: assert property (
        cpu_abort |-> $past(cpu_acc.valid))
        else $error("abort without an access");
endmodule

bind security_event_monitor sem_checker i_chk (.clk(clk), .nrst(nrst),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .det_raw(det_raw),
    .ext_clk_filt(ext_clk_filt), .cpu_acc(cpu_acc), .cpu_abort(cpu_abort),
    .test_pw_valid(test_pw_valid), .test_pw(test_pw),
    .test_cmd_valid(test_cmd_valid), .test_checksum_ok(test_checksum_ok),
    .test_cmd_ok(test_cmd_ok),
    .test_pass(test_pass), .chip_reset_req(chip_reset_req),
    .life_state(life_state));

// ### bench/cpu_model.sv
// processor-side model: issues one monitored access and watches for abort
`timescale 1ns/1ps

module cpu_model
    import sec_mon_pkg::*;
(
    // clock
    input wire logic clk,
    // access
    output cpu_acc_type cpu_acc,
    output logic [7:0] eeprom_region,
    output logic eeprom_fetch,
    // trap
    input wire logic cpu_abort
);
    initial begin
        cpu_acc = '0;
        eeprom_region = 8'h00;
        eeprom_fetch = 1'b0;
    end

    // one-cycle access; a real core would stall on abort, here it is dropped
    task go(input logic w, f, input logic [15:0] a, input logic [7:0] r,
            output logic ab);
        ab = 1'b0;
        cpu_acc <= '{1'b1, w, f, 1'b1, a};
        eeprom_fetch <= f;
        eeprom_region <= r;
        @(posedge clk);
        cpu_acc <= '0;
        eeprom_fetch <= 1'b0;
        eeprom_region <= ~r;
        repeat (3) begin
            @(posedge clk);
            if (cpu_abort === 1'b1) ab = 1'b1;
        end
    endtask
endmodule

// ### bench/test_security_event_monitor.sv
// self-checking bench for the security event monitor
`timescale 1ns/1ps

module test_security_event_monitor
    import sec_mon_pkg::*;
;
    logic clk, nrst, hsel, hwrite, priv, pw_v, cmd_v, rp, cp, ab;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, pw, rdat;
    logic [NUM_DET-1:0] det;
    logic [31:0] hrdata;
    logic hreadyout, hresp, rf, cf, abort, cmd_ok, tpass, crr, irq_out;
    logic efetch, csum, cf_prev;
    logic [7:0] ereg;
    logic [1:0] life;
    cpu_acc_type acc;
    int fail_count, checks_done, lo, ch;

    security_event_monitor i_dut (.clk(clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hprot_priv(priv),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .det_raw(det), .ext_rst_n_pad(rp), .ext_clk_pad(cp),
        .ext_rst_n_filt(rf), .ext_clk_filt(cf), .cpu_acc(acc),
        .eeprom_region(ereg), .eeprom_fetch(efetch), .cpu_abort(abort),
        .test_pw_valid(pw_v), .test_pw(pw), .test_cmd_valid(cmd_v),
        .test_checksum_ok(csum), .test_cmd_ok(cmd_ok), .test_pass(tpass),
        .chip_reset_req(crr), .fast_interrupt_request(irq_out),
        .life_state(life));
    cpu_model i_cpu (.clk(clk), .cpu_acc(acc), .eeprom_region(ereg),
        .eeprom_fetch(efetch), .cpu_abort(abort));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task summarize;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    // single word transfer; read data is taken at the edge ending the wait
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdat = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, rdat, e);
    endtask

    task tst(input logic p, input logic [31:0] w);
        if (p) pw_v <= 1'b1;
        else cmd_v <= 1'b1;
        pw <= w;
        @(posedge clk);
        pw_v <= 1'b0;
        cmd_v <= 1'b0;
        @(posedge clk);
    endtask

    task t_detect;
        logic fat;
        wr(OFS_REACT, 32'h0);
        for (int i = 0; i < NUM_DET; i++) begin
            fat = i == DET_FREQ || i == DET_VOLT || i == DET_TEMP ||
                i == DET_GLITCH;
            det[i] <= 1'b1;
            repeat (6) @(posedge clk);
            chk("reset", {31'h0, crr}, {31'h0, fat});
            rd("event", OFS_EVENT, 32'h1 << i);
            wr(OFS_EVENT, 32'h1 << i);
            det[i] <= 1'b0;
            repeat (20) @(posedge clk);
        end
        rd("flag", OFS_IRQ_STATUS, 32'h1 << IRQ_DET);
        chk("irq_masked", {31'h0, irq_out}, 32'h0);
        wr(OFS_IRQ_ENABLE, 32'h1 << IRQ_DET);
        repeat (2) @(posedge clk);
        chk("irq_on", {31'h0, irq_out}, 32'h1);
        wr(OFS_IRQ_CLEAR, 32'h1F);
        repeat (2) @(posedge clk);
        chk("irq_off", {31'h0, irq_out}, 32'h0);
        wr(OFS_REACT, 32'h7F);
        det[DET_SHIELD] <= 1'b1;
        repeat (6) @(posedge clk);
        chk("shield", {31'h0, crr}, 32'h1);
        det[DET_SHIELD] <= 1'b0;
        repeat (20) @(posedge clk);
    endtask

    task prot_bit(input logic w, f, input logic [15:0] a);
        wr(OFS_IRQ_CLEAR, 32'h1F);
        i_cpu.go(w, f, a, 8'h02, ab);
        xfer(1'b0, OFS_IRQ_STATUS, 32'h0);
    endtask

    initial begin
        fail_count = 0;
        checks_done = 0;
        {hsel, hwrite, pw_v, cmd_v, cp} = '0;
        {priv, rp, csum} = 3'b111;
        htrans = 2'h0;
        {haddr, hwdata, pw} = '0;
        det = '0;
        nrst = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd("react", OFS_REACT, {25'h0, REACT_RESET});
        rd("exec", OFS_EXEC_ALLOW, 32'h0);
        rd("p_attr", OFS_PART_BASE + 8'h08, 32'h0);
        rd("unmapped", 8'hFC, 32'h0);
        t_detect;
        priv <= 1'b0;
        wr(OFS_IRQ_ENABLE, 32'h1F);
        rd("user_rd", OFS_IRQ_ENABLE, 32'h0);
        priv <= 1'b1;
        rd("priv_rd", OFS_IRQ_ENABLE, 32'h1);
        rd("priv_st", OFS_IRQ_STATUS, 32'h1 << IRQ_PRIV);
        wr(OFS_PART_BASE, 32'h1000);
        wr(OFS_PART_BASE + 8'h04, 32'h1FFF);
        wr(OFS_PART_BASE + 8'h08, 32'hD);
        i_cpu.go(1'b0, 1'b0, 16'h1100, 8'h00, ab);
        chk("rd_ok", {31'h0, ab}, 32'h0);
        prot_bit(1'b1, 1'b0, 16'h1100);
        chk("wr_trap", {31'h0, ab & rdat[IRQ_PROT]}, 32'h1);
        prot_bit(1'b0, 1'b0, 16'h8000);
        chk("invalid", {31'h0, rdat[IRQ_INVALID]}, 32'h1);
        prot_bit(1'b0, 1'b1, 16'h1100);
        chk("exec_bad", {31'h0, rdat[IRQ_EXEC]}, 32'h1);
        wr(OFS_EXEC_ALLOW, 32'h4);
        prot_bit(1'b0, 1'b1, 16'h1100);
        chk("exec_ok", {31'h0, rdat[IRQ_EXEC]}, 32'h0);
        tst(1'b0, 32'h0);
        chk("cmd_lock", {31'h0, cmd_ok}, 32'h0);
        tst(1'b1, ~TEST_PASSWORD);
        rd("bad_pw", OFS_MODE, {30'h0, LC_LOCKED});
        tst(1'b1, TEST_PASSWORD);
        // life_state is one register behind the state itself
        @(posedge clk);
        chk("good_pw", {30'h0, life}, {30'h0, LC_TEST});
        tst(1'b0, 32'h0);
        chk("cmd_test", {31'h0, cmd_ok}, 32'h1);
        chk("csum_ok", {31'h0, tpass}, 32'h1);
        csum <= 1'b0;
        tst(1'b0, 32'h0);
        chk("csum_bad", {31'h0, tpass}, 32'h0);
        rd("mode", OFS_MODE, {30'h0, LC_TEST});
        wr(OFS_MODE, 32'h1);
        tst(1'b1, TEST_PASSWORD);
        rd("relock", OFS_MODE, {30'h0, LC_NORMAL});
        tst(1'b0, 32'h0);
        chk("cmd_norm", {31'h0, cmd_ok}, 32'h0);
        chk("life", {30'h0, life}, {30'h0, LC_NORMAL});
        for (int ph = 1; ph < 9; ph += 7) begin
            lo = 0;
            ch = 0;
            rp <= 1'b0;
            for (int k = 0; k < 40; k++) begin
                @(posedge clk);
                if (k == ph - 1) rp <= 1'b1;
                if (k % ph == ph - 1) cp <= ~cp;
                if (rf !== 1'b1) lo++;
                if (k > 0 && cf !== cf_prev) ch++;
                cf_prev = cf;
            end
            chk("rst_filt", {31'h0, lo > 0}, {31'h0, ph > 1});
            chk("clk_filt", {31'h0, ch > 0}, {31'h0, ph > 1});
        end
        summarize;
    end

    // the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        fail_count++;
        summarize;
    end
endmodule
